/* File: design/tdo_bank.sv */
// Register bank end: override, address, trace control and MMU test staging.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module tdo_bank (
    input  wire logic                i_mclk,
    input  wire logic                i_reset_n,
    tdo_if.bank                      cp,
    input  wire logic                i_data_tlb_miss,
    input  wire logic                i_instruction_tlb_miss,
    input  wire logic                i_mmu_enable,
    input  wire logic                i_dcache_enable,
    input  wire logic                i_store_uncached_buffered,
    input  wire logic                i_trace_fifo_full,
    input  wire logic                i_fast_interrupt_n,
    input  wire logic                i_normal_interrupt_n,
    output logic                     o_clean_all,
    output logic                     o_data_tlb_abort,
    output logic                     o_instruction_tlb_abort,
    output logic                     o_walk_inhibit,
    output logic [3:0]               o_fault_status,
    output logic                     o_prefetch_disable,
    output logic                     o_clock_gate_disable,
    output logic                     o_force_uncached_unbuffered,
    output logic [1:0]               o_flat_data_attr,
    output logic                     o_core_stall,
    output logic                     o_tlb_write,
    output logic                     o_tlb_lockdown,
    output logic                     o_tlb_way,
    output logic [4:0]               o_tlb_index,
    output logic [31:0]              o_tlb_tag,
    output logic [31:0]              o_tlb_pa
);

    // ------------------------------------------------------------------
    // Transfer decode
    // ------------------------------------------------------------------
    logic        wr_op;
    logic        rd_op;
    logic        is_mmu;
    logic        sel_lock;
    logic        sel_main;
    assign wr_op    = cp.valid & cp.load;
    assign rd_op    = cp.valid & ~cp.load;
    assign is_mmu   = (cp.opcode_1 == tdo_pkg::OP1_MMU_A) | (cp.opcode_1 == tdo_pkg::OP1_MMU_B);
    assign sel_main = is_mmu & (cp.opcode_2 == tdo_pkg::OP2_MAIN);
    assign sel_lock = is_mmu & (cp.opcode_2 == tdo_pkg::OP2_LOCK);

    logic        hit_ovr;
    logic        hit_addr;
    logic        hit_trc;
    assign hit_ovr  = (cp.opcode_1 == tdo_pkg::OP1_SYS) & (cp.crm == tdo_pkg::CRM_OVERRIDE)
                    & (cp.opcode_2 == tdo_pkg::OP2_MAIN);
    assign hit_addr = (cp.opcode_1 == tdo_pkg::OP1_SYS) & (cp.crm == tdo_pkg::CRM_ADDR)
                    & (cp.opcode_2 == tdo_pkg::OP2_MAIN);
    assign hit_trc  = (cp.opcode_1 == tdo_pkg::OP1_TRACE) & (cp.crm == tdo_pkg::CRM_ADDR)
                    & (cp.opcode_2 == tdo_pkg::OP2_MAIN);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [31:0] ovr_ff, nxt_ovr;
    logic [31:0] addr_ff, nxt_addr;
    logic [31:0] trc_ff, nxt_trc;
    logic [31:0] mtag_ff, nxt_mtag;
    logic [31:0] mpa_ff, nxt_mpa;
    logic [31:0] ltag_ff, nxt_ltag;
    logic [31:0] lpa_ff, nxt_lpa;
    logic        rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        twr_ff, nxt_twr;
    logic        tlock_ff, nxt_tlock;
    logic [31:0] ttag_ff, nxt_ttag;
    logic [31:0] tpa_ff, nxt_tpa;

    always_comb begin
        nxt_ovr    = ovr_ff;
        nxt_addr   = addr_ff;
        nxt_trc    = trc_ff;
        nxt_mtag   = mtag_ff;
        nxt_mpa    = mpa_ff;
        nxt_ltag   = ltag_ff;
        nxt_lpa    = lpa_ff;
        nxt_rvalid = rd_op;
        nxt_rdata  = 32'h0000_0000;
        nxt_twr    = 1'b0;
        nxt_tlock  = tlock_ff;
        nxt_ttag   = ttag_ff;
        nxt_tpa    = tpa_ff;
        if (wr_op) begin
            if (hit_ovr) begin
                nxt_ovr = cp.wdata & tdo_pkg::OVR_WMASK;
            end else if (hit_addr) begin
                nxt_addr = cp.wdata;
            end else if (hit_trc) begin
                nxt_trc = cp.wdata & tdo_pkg::TRC_WMASK;
            end else if (sel_main && cp.crm == tdo_pkg::CRM_TAG_WR) begin
                nxt_mtag = cp.wdata;
            end else if (sel_main && cp.crm == tdo_pkg::CRM_PA_WR) begin
                nxt_mpa = cp.wdata;
            end else if (sel_main && cp.crm == tdo_pkg::CRM_XFER) begin
                nxt_twr   = 1'b1;
                nxt_tlock = 1'b0;
                nxt_ttag  = mtag_ff;
                nxt_tpa   = mpa_ff;
            end else if (sel_lock && cp.crm == tdo_pkg::CRM_TAG_WR) begin
                nxt_ltag = cp.wdata;
            end else if (sel_lock && cp.crm == tdo_pkg::CRM_PA_WR) begin
                nxt_lpa = cp.wdata;
            end else if (sel_lock && cp.crm == tdo_pkg::CRM_XFER) begin
                nxt_twr   = 1'b1;
                nxt_tlock = 1'b1;
                nxt_ttag  = ltag_ff;
                nxt_tpa   = lpa_ff;
            end
        end else if (rd_op) begin
            if (hit_ovr) begin
                nxt_rdata = ovr_ff;
            end else if (hit_addr) begin
                nxt_rdata = addr_ff;
            end else if (hit_trc) begin
                nxt_rdata = trc_ff;
            end else if (sel_main && cp.crm == tdo_pkg::CRM_TAG_RD) begin
                nxt_rdata = mtag_ff;
            end else if (sel_main && cp.crm == tdo_pkg::CRM_PA_RD) begin
                nxt_rdata = mpa_ff;
            end else if (sel_lock && cp.crm == tdo_pkg::CRM_TAG_RD) begin
                nxt_rdata = ltag_ff;
            end else if (sel_lock && cp.crm == tdo_pkg::CRM_PA_RD) begin
                nxt_rdata = lpa_ff;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ovr_ff    <= tdo_pkg::OVR_RESET;
            addr_ff   <= tdo_pkg::ADDR_RESET;
            trc_ff    <= tdo_pkg::TRC_RESET;
            mtag_ff   <= 32'h0000_0000;
            mpa_ff    <= 32'h0000_0000;
            ltag_ff   <= 32'h0000_0000;
            lpa_ff    <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            twr_ff    <= 1'b0;
            tlock_ff  <= 1'b0;
            ttag_ff   <= 32'h0000_0000;
            tpa_ff    <= 32'h0000_0000;
        end else begin
            ovr_ff    <= nxt_ovr;
            addr_ff   <= nxt_addr;
            trc_ff    <= nxt_trc;
            mtag_ff   <= nxt_mtag;
            mpa_ff    <= nxt_mpa;
            ltag_ff   <= nxt_ltag;
            lpa_ff    <= nxt_lpa;
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            twr_ff    <= nxt_twr;
            tlock_ff  <= nxt_tlock;
            ttag_ff   <= nxt_ttag;
            tpa_ff    <= nxt_tpa;
        end
    end

    assign cp.rvalid = rvalid_ff;
    assign cp.rdata  = rdata_ff;

    // ------------------------------------------------------------------
    // Behaviour controls, registered so every output leaves a flip-flop
    // ------------------------------------------------------------------
    logic [15:0] ctl_ff, nxt_ctl;
    logic [3:0]  fault_ff, nxt_fault;
    logic [1:0]  attr_ff, nxt_attr;

    always_comb begin
        nxt_ctl     = 16'h0000;
        nxt_ctl[0]  = nxt_ovr[tdo_pkg::OVR_CLEAN_ALL];
        nxt_ctl[1]  = i_data_tlb_miss & nxt_ovr[tdo_pkg::OVR_MISS_DATA];
        nxt_ctl[2]  = i_instruction_tlb_miss & nxt_ovr[tdo_pkg::OVR_MISS_INSN];
        nxt_ctl[3]  = nxt_ctl[1] | nxt_ctl[2];
        nxt_ctl[4]  = nxt_ovr[tdo_pkg::OVR_NO_PREFETCH];
        nxt_ctl[5]  = nxt_ovr[tdo_pkg::OVR_NO_CLKGATE];
        nxt_ctl[6]  = i_store_uncached_buffered & nxt_ovr[tdo_pkg::OVR_UNBUF];
        // A pending interrupt holds off the stall unless its policy bit is set.
        nxt_ctl[7]  = i_trace_fifo_full
                    & (i_fast_interrupt_n | nxt_trc[tdo_pkg::TRC_FAST_STALL])
                    & (i_normal_interrupt_n | nxt_trc[tdo_pkg::TRC_NORM_STALL]);
        nxt_fault   = nxt_ctl[3] ? tdo_pkg::FAULT_XLATE : fault_ff;
        nxt_attr    = tdo_pkg::ATTR_UNCACHED_UNBUFFERED;
        if (!i_mmu_enable && i_dcache_enable && nxt_ovr[tdo_pkg::OVR_FLAT_THRU]) begin
            nxt_attr = tdo_pkg::ATTR_WRITE_THROUGH;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctl_ff   <= 16'h0000;
            fault_ff <= 4'h0;
            attr_ff  <= tdo_pkg::ATTR_UNCACHED_UNBUFFERED;
        end else begin
            ctl_ff   <= nxt_ctl;
            fault_ff <= nxt_fault;
            attr_ff  <= nxt_attr;
        end
    end

    assign o_clean_all                 = ctl_ff[0];
    assign o_data_tlb_abort            = ctl_ff[1];
    assign o_instruction_tlb_abort     = ctl_ff[2];
    assign o_walk_inhibit              = ctl_ff[3];
    assign o_fault_status              = fault_ff;
    assign o_prefetch_disable          = ctl_ff[4];
    assign o_clock_gate_disable        = ctl_ff[5];
    assign o_force_uncached_unbuffered = ctl_ff[6];
    assign o_flat_data_attr            = attr_ff;
    assign o_core_stall                = ctl_ff[7];
    assign o_tlb_write                 = twr_ff;
    assign o_tlb_lockdown              = tlock_ff;
    assign o_tlb_way                   = addr_ff[tdo_pkg::ADDR_WAY];
    assign o_tlb_index                 = addr_ff[tdo_pkg::ADDR_IDX_HI:tdo_pkg::ADDR_IDX_LO];
    assign o_tlb_tag                   = ttag_ff;
    assign o_tlb_pa                    = tpa_ff;

endmodule
`default_nettype wire

/* File: design/tdo_pkg.sv */
// Package of constants and types for the test and debug override register bank.
package tdo_pkg;

    // ------------------------------------------------------------------
    // Coprocessor transfer decode
    // ------------------------------------------------------------------
    localparam logic [2:0] OP1_SYS      = 3'h0;
    localparam logic [2:0] OP1_TRACE    = 3'h1;
    localparam logic [2:0] OP1_MMU_A    = 3'h4;
    localparam logic [2:0] OP1_MMU_B    = 3'h5;
    localparam logic [2:0] OP2_MAIN     = 3'h0;
    localparam logic [2:0] OP2_LOCK     = 3'h1;
    localparam logic [3:0] CRM_OVERRIDE = 4'h0;
    localparam logic [3:0] CRM_ADDR     = 4'h1;
    localparam logic [3:0] CRM_TAG_RD   = 4'h2;
    localparam logic [3:0] CRM_TAG_WR   = 4'h3;
    localparam logic [3:0] CRM_PA_RD    = 4'h4;
    localparam logic [3:0] CRM_PA_WR    = 4'h5;
    localparam logic [3:0] CRM_XFER     = 4'h7;

    // ------------------------------------------------------------------
    // Register fields and reset values
    // ------------------------------------------------------------------
    localparam int          OVR_CLEAN_ALL   = 19;
    localparam int          OVR_MISS_DATA   = 18;
    localparam int          OVR_MISS_INSN   = 17;
    localparam int          OVR_NO_PREFETCH = 16;
    localparam int          OVR_NO_CLKGATE  = 15;
    localparam int          OVR_UNBUF       = 14;
    localparam int          OVR_FLAT_THRU   = 13;
    localparam logic [31:0] OVR_WMASK       = 32'h000F_E000;
    localparam logic [31:0] OVR_RESET       = 32'h0000_0000;
    localparam int          TRC_FAST_STALL  = 2;
    localparam int          TRC_NORM_STALL  = 1;
    localparam logic [31:0] TRC_WMASK       = 32'h0000_0006;
    localparam logic [31:0] TRC_RESET       = 32'h0000_0000;
    localparam logic [31:0] ADDR_RESET      = 32'h0000_0000;
    localparam int          ADDR_WAY        = 31;
    localparam int          ADDR_IDX_HI     = 14;
    localparam int          ADDR_IDX_LO     = 10;
    localparam logic [3:0]  FAULT_XLATE     = 4'h0;

    // ------------------------------------------------------------------
    // Level-one data attributes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ATTR_UNCACHED_UNBUFFERED = 2'b00,
        ATTR_UNCACHED_BUFFERED   = 2'b01,
        ATTR_WRITE_THROUGH       = 2'b10,
        ATTR_WRITE_BACK          = 2'b11
    } tdo_attr_t;

    // ------------------------------------------------------------------
    // Core-side sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_WAIT = 2'b01,
        CS_DONE = 2'b10
    } tdo_cstate_t;

    // Software command register indices on the core end.
    localparam logic [2:0] SW_CMD    = 3'h0;
    localparam logic [2:0] SW_WDATA  = 3'h1;
    localparam logic [2:0] SW_RDATA  = 3'h2;
    localparam logic [2:0] SW_STATUS = 3'h3;
    localparam int         CMD_L     = 16;
    localparam int         CMD_GO    = 17;

endpackage

/* File: design/tdo_if.sv */
// Interface carrying coprocessor register transfers between core and register bank.
`timescale 1ns/10ps
`default_nettype none
interface tdo_if;
    logic        valid;
    logic        load;
    logic [2:0]  opcode_1;
    logic [3:0]  crm;
    logic [2:0]  opcode_2;
    logic [31:0] wdata;
    logic        rvalid;
    logic [31:0] rdata;

    modport bank (
        input  valid, load, opcode_1, crm, opcode_2, wdata,
        output rvalid, rdata
    );
    modport core (
        output valid, load, opcode_1, crm, opcode_2, wdata,
        input  rvalid, rdata
    );
endinterface
`default_nettype wire

/* File: design/tdo_core.sv */
// Core end: issues coprocessor transfers ordered through a small software port.
`timescale 1ns/10ps
`default_nettype none
module tdo_core (
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic [2:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [31:0]      o_rdata,
    tdo_if.core              cp
);

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    tdo_pkg::tdo_cstate_t st_ff, nxt_st;
    logic [10:0] cmd_ff, nxt_cmd;
    logic [31:0] wd_ff, nxt_wd;
    logic [31:0] res_ff, nxt_res;
    logic        valid_ff, nxt_valid;
    logic [31:0] rd_ff, nxt_rd;

    always_comb begin
        nxt_st    = st_ff;
        nxt_cmd   = cmd_ff;
        nxt_wd    = wd_ff;
        nxt_res   = res_ff;
        nxt_valid = 1'b0;
        nxt_rd    = 32'h0000_0000;
        if (i_wr && i_addr == tdo_pkg::SW_WDATA) begin
            nxt_wd = i_wdata;
        end else if (i_wr && i_addr == tdo_pkg::SW_CMD && st_ff != tdo_pkg::CS_WAIT) begin
            nxt_cmd = i_wdata[10:0];
            if (i_wdata[tdo_pkg::CMD_GO]) begin
                nxt_valid = 1'b1;
                nxt_st    = i_wdata[tdo_pkg::CMD_L] ? tdo_pkg::CS_DONE : tdo_pkg::CS_WAIT;
            end
        end
        case (st_ff)
            tdo_pkg::CS_WAIT: begin
                if (cp.rvalid) begin
                    nxt_res = cp.rdata;
                    nxt_st  = tdo_pkg::CS_DONE;
                end
            end
            default: begin
            end
        endcase
        if (i_rd) begin
            if (i_addr == tdo_pkg::SW_CMD) begin
                nxt_rd = {21'h000000, cmd_ff};
            end else if (i_addr == tdo_pkg::SW_WDATA) begin
                nxt_rd = wd_ff;
            end else if (i_addr == tdo_pkg::SW_RDATA) begin
                nxt_rd = res_ff;
            end else if (i_addr == tdo_pkg::SW_STATUS) begin
                nxt_rd = {30'h00000000, st_ff};
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_ff    <= tdo_pkg::CS_IDLE;
            cmd_ff   <= 11'h000;
            wd_ff    <= 32'h0000_0000;
            res_ff   <= 32'h0000_0000;
            valid_ff <= 1'b0;
            rd_ff    <= 32'h0000_0000;
        end else begin
            st_ff    <= nxt_st;
            cmd_ff   <= nxt_cmd;
            wd_ff    <= nxt_wd;
            res_ff   <= nxt_res;
            valid_ff <= nxt_valid;
            rd_ff    <= nxt_rd;
        end
    end

    // Command word: [2:0] second opcode, [6:3] secondary register, [9:7] first opcode,
    // [10] copy of the load bit, bit 16 load, bit 17 go.
    assign cp.valid    = valid_ff;
    assign cp.load     = cmd_ff[10];
    assign cp.opcode_2 = cmd_ff[2:0];
    assign cp.crm      = cmd_ff[6:3];
    assign cp.opcode_1 = cmd_ff[9:7];
    assign cp.wdata    = wd_ff;
    assign o_rdata     = rd_ff;

endmodule
`default_nettype wire

/* File: bench/tdo_bank_asserts.sv */
// Checker watching the coprocessor transfer interface between core and register bank.
`timescale 1ns/10ps
`default_nettype none
module tdo_bank_asserts (
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_valid,
    input  wire logic        i_load,
    input  wire logic [2:0]  i_opcode_1,
    input  wire logic [3:0]  i_crm,
    input  wire logic [2:0]  i_opcode_2,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_rvalid,
    input  wire logic [31:0] i_rdata
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    // ------------------------------------------------------------------
    // Transfer steps
    // ------------------------------------------------------------------
    sequence s_read;
        i_valid && !i_load;
    endsequence
    sequence s_sel(o1, c);
        i_opcode_1 == o1 && i_crm == c && i_opcode_2 == 3'h0;
    endsequence

    chk_read_answer: assert property (s_read |=> i_rvalid)
        else $error("read transfer got no answer");
    chk_write_silent: assert property (i_valid && i_load |=> !i_rvalid)
        else $error("write transfer got an answer");
    chk_no_stray: assert property (i_rvalid |-> $past(i_valid && !i_load))
        else $error("answer without a read");
    chk_idle_rdata: assert property (!i_rvalid |-> i_rdata == 32'h0)
        else $error("read data not zero outside answer");
    chk_valid_pulse: assert property (i_valid |=> !i_valid)
        else $error("transfer strobe longer than one cycle");
    chk_ovr_reserved: assert property (s_read ##0 s_sel(3'h0, 4'h0) |=>
        (i_rdata & ~tdo_pkg::OVR_WMASK) == 32'h0) else $error("override reserved bits set");
    chk_trc_reserved: assert property (s_read ##0 s_sel(3'h1, 4'h1) |=>
        (i_rdata & ~tdo_pkg::TRC_WMASK) == 32'h0) else $error("trace reserved bits set");
    chk_unmapped_zero: assert property (s_read ##0 i_opcode_1 == 3'h2 |=>
        i_rvalid && i_rdata == 32'h0) else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* File: bench/tb_tdo_bank.sv */
// Testbench joining core end and register bank end across the transfer interface.
`timescale 1ns/10ps
`default_nettype none
module tb_tdo_bank;
    logic        i_mclk    = 1'b0;
    logic        i_reset_n = 1'b0;
    logic [2:0]  i_addr    = 3'h0;
    logic [31:0] i_wdata   = 32'h0;
    logic        i_wr      = 1'b0;
    logic        i_rd      = 1'b0;
    logic [7:0]  sd        = 8'h0;
    logic [31:0] o_rdata, rd, tg, pa, o_tag, o_pa;
    logic        cl, da, ia, wi, pf, cg, fn, st, tw, lk, way;
    logic [3:0]  fs;
    logic [1:0]  at;
    logic [4:0]  idx;
    logic [2:0]  o1, o2;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          nwr       = 0;

    tdo_if cp ();
    tdo_core tdo_core_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .cp(cp.core));
    tdo_bank tdo_bank_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .cp(cp.bank),
        .i_data_tlb_miss(sd[7]), .i_instruction_tlb_miss(sd[6]), .i_mmu_enable(sd[5]),
        .i_dcache_enable(sd[4]), .i_store_uncached_buffered(sd[3]),
        .i_trace_fifo_full(sd[2]), .i_fast_interrupt_n(sd[1]), .i_normal_interrupt_n(sd[0]),
        .o_clean_all(cl), .o_data_tlb_abort(da), .o_instruction_tlb_abort(ia),
        .o_walk_inhibit(wi), .o_fault_status(fs), .o_prefetch_disable(pf),
        .o_clock_gate_disable(cg), .o_force_uncached_unbuffered(fn),
        .o_flat_data_attr(at), .o_core_stall(st),
        .o_tlb_write(tw), .o_tlb_lockdown(lk), .o_tlb_way(way), .o_tlb_index(idx),
        .o_tlb_tag(o_tag), .o_tlb_pa(o_pa));
    tdo_bank_asserts tdo_bank_asserts_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_valid(cp.valid), .i_load(cp.load), .i_opcode_1(cp.opcode_1),
        .i_crm(cp.crm), .i_opcode_2(cp.opcode_2), .i_wdata(cp.wdata),
        .i_rvalid(cp.rvalid), .i_rdata(cp.rdata));

    always #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (tw === 1'b1) nwr <= nwr + 1;

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic sw(input logic wr, input logic [2:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= wr;
        i_rd    <= !wr;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1 rd = o_rdata;
    endtask
    // Issues one transfer through the software port and leaves a read result in rd.
    task automatic xfer(input logic l, input logic [2:0] a1, input logic [3:0] c,
                        input logic [2:0] a2, input logic [31:0] d);
        sw(1'b1, 3'h1, d);
        sw(1'b1, 3'h0, 32'h0002_0000 | {15'h0, l, 5'h0, l, a1, c, a2});
        for (int n = 0; n < 8; n++) begin
            sw(1'b0, 3'h3, 32'h0);
            if (rd === 32'h2) break;
        end
        check("status", rd, 32'h2);
        sw(1'b0, 3'h2, 32'h0);
    endtask
    task automatic side(input logic [7:0] v);
        @(posedge i_mclk);
        sd <= v;
        repeat (3) @(posedge i_mclk);
        #1;
    endtask
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        xfer(1'b0, 3'h0, 4'h0, 3'h0, 32'h0);
        check("override", rd, tdo_pkg::OVR_RESET);
        xfer(1'b0, 3'h1, 4'h1, 3'h0, 32'h0);
        check("trace", rd, tdo_pkg::TRC_RESET);
        side(8'b1101_1011);
        check("dabort", da, 32'h0);
        check("iabort", ia, 32'h0);
        check("attr", at, 32'h0);
        check("force", fn, 32'h0);
        check("clean", cl, 32'h0);
        xfer(1'b1, 3'h0, 4'h0, 3'h0, 32'hFFFF_FFFF);
        xfer(1'b0, 3'h0, 4'h0, 3'h0, 32'h0);
        check("override", rd, tdo_pkg::OVR_WMASK);
        side(8'b1101_1011);
        check("clean", cl, 32'h1);
        check("dabort", da, 32'h1);
        check("iabort", ia, 32'h1);
        check("walk", wi, 32'h1);
        check("fault", fs, 32'h0);
        check("prefetch", pf, 32'h1);
        check("gating", cg, 32'h1);
        check("force", fn, 32'h1);
        check("attr", at, 32'h2);
        side(8'b1100_0011);
        check("attr", at, 32'h0);
        xfer(1'b1, 3'h0, 4'h0, 3'h0, 32'h0004_0000);
        side(8'b1100_0011);
        check("dabort", da, 32'h1);
        check("iabort", ia, 32'h0);
        for (int t = 0; t < 4; t++) begin
            xfer(1'b1, 3'h1, 4'h1, 3'h0, 32'hFFFF_FFF9 | (t << 1));
            xfer(1'b0, 3'h1, 4'h1, 3'h0, 32'h0);
            check("trace", rd, t << 1);
            side(8'h3);
            check("stall", st, 32'h0);
            for (int k = 0; k < 4; k++) begin
                side({6'b0000_01, k[1:0]});
                check("stall", st, (k[1] | t[1]) & (k[0] | t[0]));
            end
        end
        xfer(1'b1, 3'h0, 4'h1, 3'h0, 32'h8000_5400);
        xfer(1'b0, 3'h0, 4'h1, 3'h0, 32'h0);
        check("address", rd, 32'h8000_5400);
        check("way", way, 32'h1);
        check("index", idx, 32'h15);
        for (int j = 0; j < 4; j++) begin
            o1 = j[0] ? 3'h5 : 3'h4;
            o2 = {2'b00, j[1]};
            tg = 32'hA5A5_0000 + j;
            pa = 32'h5A5A_0000 + j;
            xfer(1'b1, o1, 4'h3, o2, tg);
            xfer(1'b1, o1, 4'h5, o2, pa);
            xfer(1'b1, o1, 4'h7, o2, 32'h0);
            check("writes", nwr, j + 1);
            check("lockdown", lk, j[1]);
            check("tag", o_tag, tg);
            check("pa", o_pa, pa);
            xfer(1'b0, o1, 4'h2, o2, 32'h0);
            check("tag_rd", rd, tg);
            xfer(1'b0, o1, 4'h4, o2, 32'h0);
            check("pa_rd", rd, pa);
        end
        xfer(1'b0, 3'h2, 4'h0, 3'h0, 32'h0);
        check("unmapped", rd, 32'h0);
        // Reset in mid-run must clear the written override, trace and address values.
        @(posedge i_mclk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        xfer(1'b0, 3'h0, 4'h0, 3'h0, 32'h0);
        check("override", rd, tdo_pkg::OVR_RESET);
        xfer(1'b0, 3'h1, 4'h1, 3'h0, 32'h0);
        check("trace", rd, tdo_pkg::TRC_RESET);
        check("way", way, 32'h0);
        stop_test;
    end

    initial begin
        #200000;
        error_cnt++;
        stop_test;
    end
endmodule
`default_nettype wire
